// file: rtl/irwt_pkg.sv
// constants for the infrared wide timer with ping-pong output
// assumes a 32-bit classic wishbone slave port; each register is one aligned word
package irwt_pkg;

  localparam int WB_AW = 6;
  localparam int WB_DW = 32;

  // register byte addresses
  localparam logic [5:0] ADR_NARROW_CTRL   = 6'h00;
  localparam logic [5:0] ADR_SHARED_CTRL   = 6'h04;
  localparam logic [5:0] ADR_WIDE_CTRL     = 6'h08;
  localparam logic [5:0] ADR_WIDE_RLD_HI   = 6'h0C;
  localparam logic [5:0] ADR_WIDE_RLD_LO   = 6'h10;
  localparam logic [5:0] ADR_NARROW_RLD_HI = 6'h14;
  localparam logic [5:0] ADR_NARROW_RLD_LO = 6'h18;
  localparam logic [5:0] ADR_WIDE_CAP_HI   = 6'h1C;
  localparam logic [5:0] ADR_WIDE_CAP_LO   = 6'h20;
  localparam logic [5:0] ADR_EDGE_STAT     = 6'h24;

  // narrow and wide control fields
  localparam int CTL_EN_BIT      = 7;
  localparam int CTL_SINGLE_BIT  = 6;
  localparam int CTL_TOUT_BIT    = 5;
  localparam int WIDE_CLK_LSB    = 3;
  localparam int CTL_CAPMASK_BIT = 2;
  localparam int CTL_TOMASK_BIT  = 1;
  localparam int CTL_PIN_BIT     = 0;

  // shared control fields
  localparam int SH_DEMOD_BIT   = 7;
  localparam int SH_COMB_EN_BIT = 6;
  localparam int SH_SEL_LSB     = 4;
  localparam int SH_MODE_LSB    = 2;
  localparam int SH_NINIT_BIT   = 1;
  localparam int SH_WINIT_BIT   = 0;

  // edge status fields
  localparam int EDGE_RISE_BIT = 1;
  localparam int EDGE_FALL_BIT = 0;

  // output-mode field codes
  localparam logic [1:0] OM_NORMAL   = 2'h0;
  localparam logic [1:0] OM_PINGPONG = 2'h1;
  localparam logic [1:0] OM_FORCE0   = 2'h2;
  localparam logic [1:0] OM_FORCE1   = 2'h3;

  // combined pin logic codes, shared field with edge select
  localparam logic [1:0] COMB_AND  = 2'h0;
  localparam logic [1:0] COMB_OR   = 2'h1;
  localparam logic [1:0] COMB_NOR  = 2'h2;
  localparam logic [1:0] COMB_NAND = 2'h3;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_RISE = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // reset values
  localparam logic [7:0]  CTRL_RST   = 8'h00;
  localparam logic [7:0]  RELOAD_RST = 8'h00;
  localparam logic [7:0]  CAP_RST    = 8'h00;
  localparam logic [15:0] WCNT_RST   = 16'h0000;
  localparam logic [7:0]  NCNT_RST   = 8'h00;

  // counter figures
  localparam logic [15:0] WIDE_ALL_ONES   = 16'hFFFF;
  localparam logic [7:0]  NARROW_ALL_ONES = 8'hFF;
  localparam logic [15:0] WIDE_TERM       = 16'h0001;
  localparam logic [7:0]  NARROW_TERM     = 8'h01;

  // prescaler masks for divide by 1, 2, 4, 8
  localparam logic [2:0] DIV1_MASK = 3'h0;
  localparam logic [2:0] DIV2_MASK = 3'h1;
  localparam logic [2:0] DIV4_MASK = 3'h3;
  localparam logic [2:0] DIV8_MASK = 3'h7;

endpackage

// file: rtl/irwt_prescaler.sv
// clock-select prescaler for the wide counter
// assumes one clock; tick is a one-cycle enable, never a derived clock
`timescale 1ns/1ns
`default_nettype none
module irwt_prescaler (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [1:0] div_sel,
  output logic            tick
);
  import irwt_pkg::*;

  typedef struct packed {
    logic [2:0] div_cnt_r;
  } irwt_pre_state_t;

  irwt_pre_state_t s_r;
  irwt_pre_state_t s_nxt;
  logic [2:0]      mask;

  always_comb begin
    s_nxt           = s_r;
    s_nxt.div_cnt_r = s_r.div_cnt_r + 3'h1;
    case (div_sel)
      2'h0:    mask = DIV1_MASK;
      2'h1:    mask = DIV2_MASK;
      2'h2:    mask = DIV4_MASK;
      default: mask = DIV8_MASK;
    endcase
    tick = ((s_r.div_cnt_r & mask) == mask); // RULE22
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule
`default_nettype wire

// file: rtl/irwt_timer.sv
// wide ir timer: transmit, demodulation and ping-pong with the narrow counter
// assumes rx_in and port_data are synchronous to clk; wishbone classic slave
//
// Added by the designer: the register offsets and the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// [RULE1] disabled wide output in normal or ping-pong shows inverse of initial level
// [RULE2] output-mode 10 or 11 forces wide output to 0 or 1 always
// [RULE3] transmit enable loads high*256+low reload and drives initial level
// [RULE4] transmit terminal count toggles output, sets timeout, masked interrupt pulse
// [RULE5] single-pass stops at terminal count; modulo-N reloads and keeps counting
// [RULE6] reload writes accepted anytime, used only at next load
// [RULE7] software writes all ones to both wide reloads before demodulation
// [RULE8] demodulation: first selected edge after enable captures, reloads, starts counting
// [RULE9] edge-handling 0: later edges capture complement, set edge status, reload ones
// [RULE10] edge-handling 1: ignore edges; narrow timeout captures without reload
// [RULE11] writing edge-handling 0 then 1 re-arms capture on next edge
// [RULE12] demodulation zero continues from all ones, sets timeout, masked interrupt
// [RULE13] software uses ping-pong only in transmit with both counters single-pass
// [RULE14] ping-pong: each counter's terminal count stops it and starts the other
// [RULE15] software ends ping-pong by writing 00 to output-mode field
// [RULE16] ping-pong hardware toggles both enables, sets timeouts at each terminal
// [RULE17] software never programs count 1, reloads before restarting a timer
// [RULE18] software stops counters and clears flags before enabling ping-pong
// [RULE19] pins carry narrow, wide or combined output when their bits are set
// [RULE20] narrow demodulation timeout sets status and continues from all ones
// [RULE21] writing 1 clears wide timeout status; writing 0 leaves it
// [RULE22] two-bit clock field divides wide counter clock by 1, 2, 4, 8
// [RULE23] timeout and edge status stay set until cleared, regardless of masks
module irwt_timer (
  input  wire logic                       clk,
  input  wire logic                       reset,
  input  wire logic [irwt_pkg::WB_AW-1:0] adr_i,
  input  wire logic [irwt_pkg::WB_DW-1:0] dat_i,
  output logic      [irwt_pkg::WB_DW-1:0] dat_o,
  input  wire logic                       we_i,
  input  wire logic [3:0]                 sel_i,
  input  wire logic                       cyc_i,
  input  wire logic                       stb_i,
  output logic                            ack_o,
  input  wire logic                       rx_in,
  input  wire logic [2:0]                 port_data,
  output logic                            narrow_out_pin,
  output logic                            wide_out_pin,
  output logic                            combined_out_pin,
  output logic                            wide_timeout_irq,
  output logic                            wide_capture_irq,
  output logic                            narrow_timeout_irq
);
  import irwt_pkg::*;

  typedef struct packed {
    logic [7:0]  narrow_ctrl_r, shared_ctrl_r, wide_ctrl_r;
    logic [7:0]  wide_reload_high_r, wide_reload_low_r;
    logic [7:0]  narrow_reload_high_r, narrow_reload_low_r;
    logic [7:0]  wide_capture_high_r, wide_capture_low_r;
    logic [1:0]  edge_stat_r;
    logic [15:0] wcnt_r;
    logic [7:0]  ncnt_r;
    logic        wout_r, nout_r, wloaded_r, nloaded_r;
    logic        wrun_r, wpend_r, rx_prev_r, ack_r;
    logic [7:0]  rdat_r;
    logic        npin_r, wpin_r, cpin_r;
    logic        wto_irq_r, wcap_irq_r, nto_irq_r;
  } irwt_state_t;

  irwt_state_t s;
  irwt_state_t s_nxt;

  logic       tick, req, wb_wr;
  logic [7:0] rd_byte;
  logic       demod;
  logic [1:0] omode, esel;
  logic       rise, fall, edge_hit;
  logic       n_to, n_term, w_to, w_term, w_wrap, w_load, cap_evt;
  logic       wide_level, narrow_level, comb_level;

  ////////////////////////////////////////////////////////////////////////////
  irwt_prescaler u_pre (
    .clk     (clk),
    .reset   (reset),
    .div_sel (s.wide_ctrl_r[WIDE_CLK_LSB+1:WIDE_CLK_LSB]),
    .tick    (tick)
  );

  assign req   = cyc_i & stb_i;
  // write lands on the edge where the master sees ack
  assign wb_wr = req & s.ack_r & we_i & sel_i[0];
  assign demod = s.shared_ctrl_r[SH_DEMOD_BIT];
  assign omode = s.shared_ctrl_r[SH_MODE_LSB+1:SH_MODE_LSB];
  assign esel  = s.shared_ctrl_r[SH_SEL_LSB+1:SH_SEL_LSB];
  assign rise  = rx_in & ~s.rx_prev_r;
  assign fall  = ~rx_in & s.rx_prev_r;
  assign edge_hit = (rise & esel[1]) | (fall & esel[0]); // RULE8

  assign narrow_level = s.narrow_ctrl_r[CTL_EN_BIT] ? s.nout_r
                                                     : ~s.shared_ctrl_r[SH_NINIT_BIT];
  always_comb begin
    if (omode[1]) begin
      wide_level = omode[0]; // RULE2
    end else if (s.wide_ctrl_r[CTL_EN_BIT]) begin
      wide_level = s.wout_r;
    end else begin
      wide_level = ~s.shared_ctrl_r[SH_WINIT_BIT]; // RULE1
    end
  end

  always_comb begin
    case (esel)
      COMB_AND: comb_level = narrow_level & wide_level;
      COMB_OR:  comb_level = narrow_level | wide_level;
      COMB_NOR: comb_level = ~(narrow_level | wide_level);
      default:  comb_level = ~(narrow_level & wide_level);
    endcase
  end

  always_comb begin
    case (adr_i)
      ADR_NARROW_CTRL:   rd_byte = s.narrow_ctrl_r;
      ADR_SHARED_CTRL:   rd_byte = s.shared_ctrl_r;
      ADR_WIDE_CTRL:     rd_byte = s.wide_ctrl_r;
      ADR_WIDE_RLD_HI:   rd_byte = s.wide_reload_high_r;
      ADR_WIDE_RLD_LO:   rd_byte = s.wide_reload_low_r;
      ADR_NARROW_RLD_HI: rd_byte = s.narrow_reload_high_r;
      ADR_NARROW_RLD_LO: rd_byte = s.narrow_reload_low_r;
      ADR_WIDE_CAP_HI:   rd_byte = s.wide_capture_high_r;
      ADR_WIDE_CAP_LO:   rd_byte = s.wide_capture_low_r;
      ADR_EDGE_STAT:     rd_byte = {6'h00, s.edge_stat_r};
      default:           rd_byte = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt            = s;
    n_to             = 1'b0;
    n_term           = 1'b0;
    w_to             = 1'b0;
    w_term           = 1'b0;
    w_wrap           = 1'b0;
    w_load           = 1'b0;
    cap_evt          = 1'b0;
    s_nxt.rx_prev_r  = rx_in;
    s_nxt.ack_r      = req & ~s.ack_r;
    s_nxt.wcap_irq_r = 1'b0;
    if (req & ~s.ack_r) begin
      s_nxt.rdat_r = rd_byte;
    end

    // software writes first, so hardware sets below win over clears
    if (wb_wr) begin
      case (adr_i)
        ADR_NARROW_CTRL: begin
          s_nxt.narrow_ctrl_r = {dat_i[7:6], s.narrow_ctrl_r[CTL_TOUT_BIT] & ~dat_i[5],
                                 dat_i[4:0]};
        end
        ADR_WIDE_CTRL: begin
          s_nxt.wide_ctrl_r = {dat_i[7:6], s.wide_ctrl_r[CTL_TOUT_BIT] & ~dat_i[5],
                               dat_i[4:0]}; // RULE21
          if (~s.wide_ctrl_r[CTL_SINGLE_BIT] & dat_i[CTL_SINGLE_BIT] & s.wrun_r) begin
            s_nxt.wpend_r = 1'b1; // RULE11
          end
        end
        ADR_SHARED_CTRL:   s_nxt.shared_ctrl_r = dat_i[7:0];
        ADR_WIDE_RLD_HI:   s_nxt.wide_reload_high_r = dat_i[7:0]; // RULE6
        ADR_WIDE_RLD_LO:   s_nxt.wide_reload_low_r = dat_i[7:0]; // RULE6
        ADR_NARROW_RLD_HI: s_nxt.narrow_reload_high_r = dat_i[7:0];
        ADR_NARROW_RLD_LO: s_nxt.narrow_reload_low_r = dat_i[7:0];
        ADR_EDGE_STAT:     s_nxt.edge_stat_r = s.edge_stat_r & ~dat_i[1:0];
        default: begin
        end
      endcase
    end

    // narrow counter, one count per clock
    if (!s_nxt.narrow_ctrl_r[CTL_EN_BIT]) begin
      s_nxt.nloaded_r = 1'b0;
    end else if (!s.nloaded_r) begin
      s_nxt.nloaded_r = 1'b1;
      s_nxt.nout_r    = s.shared_ctrl_r[SH_NINIT_BIT];
      if (demod) begin
        s_nxt.ncnt_r = NARROW_ALL_ONES;
      end else if (s.shared_ctrl_r[SH_NINIT_BIT]) begin
        s_nxt.ncnt_r = s.narrow_reload_high_r;
      end else begin
        s_nxt.ncnt_r = s.narrow_reload_low_r;
      end
    end else if (demod) begin
      if (s.ncnt_r == NCNT_RST) begin
        n_to         = 1'b1;
        s_nxt.ncnt_r = NARROW_ALL_ONES; // RULE20
      end else begin
        s_nxt.ncnt_r = s.ncnt_r - 8'h01;
      end
    end else if (s.ncnt_r == NARROW_TERM) begin
      n_term       = 1'b1;
      n_to         = 1'b1;
      s_nxt.nout_r = ~s.nout_r;
      if (s.narrow_ctrl_r[CTL_SINGLE_BIT]) begin
        s_nxt.narrow_ctrl_r[CTL_EN_BIT] = 1'b0;
        if (omode == OM_PINGPONG) begin
          s_nxt.wide_ctrl_r[CTL_EN_BIT] = 1'b1; // RULE14 RULE16
        end
      end else if (s.nout_r) begin
        s_nxt.ncnt_r = s.narrow_reload_low_r;
      end else begin
        s_nxt.ncnt_r = s.narrow_reload_high_r;
      end
    end else begin
      s_nxt.ncnt_r = s.ncnt_r - 8'h01;
    end

    // wide counter
    if (!s_nxt.wide_ctrl_r[CTL_EN_BIT]) begin
      s_nxt.wloaded_r = 1'b0;
      s_nxt.wrun_r    = 1'b0;
      s_nxt.wpend_r   = 1'b0;
    end else if (!s.wloaded_r) begin
      s_nxt.wloaded_r = 1'b1;
      if (demod) begin
        s_nxt.wpend_r = 1'b1; // RULE8
        s_nxt.wrun_r  = 1'b0;
      end else begin
        w_load       = 1'b1;
        s_nxt.wcnt_r = {s.wide_reload_high_r, s.wide_reload_low_r}; // RULE3
        s_nxt.wout_r = s.shared_ctrl_r[SH_WINIT_BIT]; // RULE3
      end
    end else if (demod) begin
      if (edge_hit && (s.wpend_r || (s.wrun_r && !s.wide_ctrl_r[CTL_SINGLE_BIT]))) begin
        // every accepted edge captures; edge status only once the count runs
        cap_evt       = 1'b1;
        s_nxt.wpend_r = 1'b0;
        s_nxt.wrun_r  = 1'b1;
        s_nxt.wcnt_r  = s.wpend_r ? {s.wide_reload_high_r, s.wide_reload_low_r}
                                  : WIDE_ALL_ONES; // RULE8 RULE9
        if (s.wrun_r) begin
          s_nxt.edge_stat_r = s_nxt.edge_stat_r | {rise, fall}; // RULE9 RULE23
        end
      end else if (s.wrun_r) begin
        if (s.wide_ctrl_r[CTL_SINGLE_BIT] && n_to) begin
          cap_evt = 1'b1; // RULE10
        end
        if (tick) begin
          if (s.wcnt_r == WCNT_RST) begin
            w_wrap       = 1'b1;
            w_to         = 1'b1;
            s_nxt.wcnt_r = WIDE_ALL_ONES; // RULE12
          end else begin
            s_nxt.wcnt_r = s.wcnt_r - 16'h0001;
          end
        end
      end
      if (cap_evt) begin
        s_nxt.wide_capture_high_r = ~s.wcnt_r[15:8]; // RULE9
        s_nxt.wide_capture_low_r  = ~s.wcnt_r[7:0];
        s_nxt.wcap_irq_r          = s.wide_ctrl_r[CTL_CAPMASK_BIT];
      end
    end else if (tick) begin
      if (s.wcnt_r == WIDE_TERM) begin
        w_term       = 1'b1;
        w_to         = 1'b1;
        s_nxt.wout_r = ~s.wout_r; // RULE4
        if (s.wide_ctrl_r[CTL_SINGLE_BIT]) begin
          s_nxt.wide_ctrl_r[CTL_EN_BIT] = 1'b0; // RULE5
          if (omode == OM_PINGPONG) begin
            s_nxt.narrow_ctrl_r[CTL_EN_BIT] = 1'b1; // RULE14 RULE16
          end
        end else begin
          s_nxt.wcnt_r = {s.wide_reload_high_r, s.wide_reload_low_r}; // RULE5
        end
      end else begin
        s_nxt.wcnt_r = s.wcnt_r - 16'h0001;
      end
    end

    // sticky status; set wins over a same-cycle clear
    s_nxt.wide_ctrl_r[CTL_TOUT_BIT]   = s_nxt.wide_ctrl_r[CTL_TOUT_BIT] | w_to; // RULE4 RULE23
    s_nxt.narrow_ctrl_r[CTL_TOUT_BIT] = s_nxt.narrow_ctrl_r[CTL_TOUT_BIT] | n_to; // RULE16
    s_nxt.wto_irq_r = w_to & s.wide_ctrl_r[CTL_TOMASK_BIT]; // RULE4 RULE12
    s_nxt.nto_irq_r = n_to & s.narrow_ctrl_r[CTL_TOMASK_BIT];

    // pins fall back to the port latch when not routed
    s_nxt.npin_r = s.narrow_ctrl_r[CTL_PIN_BIT] ? narrow_level : port_data[0]; // RULE19
    s_nxt.wpin_r = s.wide_ctrl_r[CTL_PIN_BIT] ? wide_level : port_data[1]; // RULE19
    s_nxt.cpin_r = s.shared_ctrl_r[SH_COMB_EN_BIT] ? comb_level : port_data[2]; // RULE19
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s                      <= '0;
      s.narrow_ctrl_r        <= CTRL_RST;
      s.shared_ctrl_r        <= CTRL_RST;
      s.wide_ctrl_r          <= CTRL_RST;
      s.wide_reload_high_r   <= RELOAD_RST;
      s.wide_reload_low_r    <= RELOAD_RST;
      s.narrow_reload_high_r <= RELOAD_RST;
      s.narrow_reload_low_r  <= RELOAD_RST;
      s.wide_capture_high_r  <= CAP_RST;
      s.wide_capture_low_r   <= CAP_RST;
      s.wcnt_r               <= WCNT_RST;
      s.ncnt_r               <= NCNT_RST;
    end else begin
      s <= s_nxt;
    end
  end

  assign dat_o              = {24'h000000, s.rdat_r};
  assign ack_o              = s.ack_r;
  assign narrow_out_pin     = s.npin_r;
  assign wide_out_pin       = s.wpin_r;
  assign combined_out_pin   = s.cpin_r;
  assign wide_timeout_irq   = s.wto_irq_r;
  assign wide_capture_irq   = s.wcap_irq_r;
  assign narrow_timeout_irq = s.nto_irq_r;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  chk_wide_idle_level: assert property ( // RULE1
    !s.wide_ctrl_r[CTL_EN_BIT] && !omode[1] |-> wide_level == ~s.shared_ctrl_r[SH_WINIT_BIT])
    else $error("idle wide output is not the inverse of its initial level");
  chk_force_level: assert property ( // RULE2
    omode[1] |-> wide_level == omode[0])
    else $error("forced wide output level is wrong");
  chk_tx_load_value: assert property ( // RULE3
    w_load |=> s.wcnt_r == {$past(s.wide_reload_high_r), $past(s.wide_reload_low_r)}
               && s.wout_r == $past(s.shared_ctrl_r[SH_WINIT_BIT]))
    else $error("wide load value or initial level wrong");
  chk_term_toggle: assert property ( // RULE4
    w_term |=> s.wout_r != $past(s.wout_r) && s.wide_ctrl_r[CTL_TOUT_BIT]
               && wide_timeout_irq == $past(s.wide_ctrl_r[CTL_TOMASK_BIT]))
    else $error("terminal count did not toggle or flag");
  chk_single_stop: assert property ( // RULE5
    w_term && s.wide_ctrl_r[CTL_SINGLE_BIT] && !wb_wr |=> !s.wide_ctrl_r[CTL_EN_BIT])
    else $error("single-pass wide counter kept running");
  chk_demod_wrap: assert property ( // RULE12
    w_wrap |=> s.wcnt_r == WIDE_ALL_ONES && s.wide_ctrl_r[CTL_TOUT_BIT])
    else $error("demodulation wrap did not reload all ones");
  chk_edge_capture: assert property ( // RULE9
    cap_evt |=> {s.wide_capture_high_r, s.wide_capture_low_r} == ~$past(s.wcnt_r))
    else $error("capture does not hold complemented count");
  chk_tout_sticky: assert property ( // RULE23
    s.wide_ctrl_r[CTL_TOUT_BIT] && !(wb_wr && adr_i == ADR_WIDE_CTRL && dat_i[CTL_TOUT_BIT])
    |=> s.wide_ctrl_r[CTL_TOUT_BIT])
    else $error("wide timeout flag dropped without a clear");
  chk_pingpong_hand: assert property ( // RULE14
    n_term && omode == OM_PINGPONG && s.narrow_ctrl_r[CTL_SINGLE_BIT] && !wb_wr
    |=> s.wide_ctrl_r[CTL_EN_BIT] && !s.narrow_ctrl_r[CTL_EN_BIT] && s.wloaded_r
        && s.wout_r == $past(s.shared_ctrl_r[SH_WINIT_BIT]))
    else $error("ping-pong hand-over failed");
  chk_wide_pin_route: assert property ( // RULE19
    s.wide_ctrl_r[CTL_PIN_BIT] |=> wide_out_pin == $past(wide_level))
    else $error("wide pin does not follow the wide output");

  cov_pingpong: cover property (n_term && omode == OM_PINGPONG ##[1:300] w_term);
  cov_demod_capture: cover property (cap_evt && !s.wide_ctrl_r[CTL_SINGLE_BIT]);
  cov_modulo_reload: cover property (w_term && !s.wide_ctrl_r[CTL_SINGLE_BIT]);

endmodule
`default_nettype wire

// file: tb/irwt_ir_model.sv
// receiver model: drives the demodulated infrared level into rx_in
// assumes the bench calls mark() from its main sequence, one burst at a time
`timescale 1ns/1ns
`default_nettype none
module irwt_ir_model (
  input  wire logic clk,
  output logic      rx
);
  // idle space is low; the receiver output is always driven, never released
  initial rx = 1'b0;
  task automatic mark(input int len);
    @(posedge clk);
    rx <= 1'b1;
    repeat (len) @(posedge clk);
    rx <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: tb/irwt_timer_bench.sv
// self-checking bench for the wide ir timer over classic wishbone
// assumes irwt_pkg register map and the one-cycle registered ack
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin bad_count++; \
  $display("wrong value %s exp %0h got %0h", n, e, s); end end
module irwt_timer_bench;
  import irwt_pkg::*;
  logic        clk;
  logic        reset;
  logic [5:0]  adr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        we;
  logic        stb;
  logic        ack;
  logic        rx;
  logic [2:0]  port_data;
  logic        n_pin;
  logic        w_pin;
  logic        c_pin;
  logic        w_to_irq;
  logic        cap_irq;
  logic        n_to_irq;
  logic        cap_seen;
  logic        nto_seen;
  logic [7:0]  rd;
  int          bad_count;
  int          num_checks;
  int          cyc_n;
  int          t1;
  int          t8;
  logic [7:0]  sh_v [4] = '{8'h00, 8'h01, 8'h08, 8'h0D};
  logic [3:0]  sh_e = 4'b1001;
  logic [3:0]  comb_e = 4'b1010;

  irwt_timer dut (.clk(clk), .reset(reset), .adr_i(adr), .dat_i(wdat), .dat_o(rdat),
    .we_i(we), .sel_i(4'hF), .cyc_i(stb), .stb_i(stb), .ack_o(ack), .rx_in(rx),
    .port_data(port_data), .narrow_out_pin(n_pin), .wide_out_pin(w_pin),
    .combined_out_pin(c_pin), .wide_timeout_irq(w_to_irq), .wide_capture_irq(cap_irq),
    .narrow_timeout_irq(n_to_irq));
  irwt_ir_model ir (.clk(clk), .rx(rx));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // whole run is about a thousand cycles; the ceiling only catches a hang
  always @(posedge clk) begin
    cyc_n++;
    if (cap_irq === 1'b1) cap_seen <= 1'b1;
    if (n_to_irq === 1'b1) nto_seen <= 1'b1;
    if (cyc_n == 20000) begin
      bad_count++;
      end_of_test();
    end
  end

  task automatic wb(input logic [5:0] a, input logic w, input logic [7:0] d,
                    output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    we <= w;
    wdat <= {24'h000000, d};
    stb <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) bad_count++;
    q = rdat[7:0];
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(a, 1'b1, d, q);
  endtask

  // pins are registered one cycle behind the internal level
  task automatic settle();
    repeat (3) @(posedge clk);
  endtask

  task automatic wait_to(output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (w_to_irq !== 1'b1 && n < 3000);
    if (w_to_irq !== 1'b1) bad_count++;
  endtask

  initial begin
    reset = 1'b1;
    adr = 6'h00;
    wdat = 32'h00000000;
    we = 1'b0;
    stb = 1'b0;
    port_data = 3'h5;
    cap_seen = 1'b0;
    nto_seen = 1'b0;
    bad_count = 0;
    num_checks = 0;
    cyc_n = 0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    settle();
    `CHK("port pins", 3'h5, {c_pin, w_pin, n_pin})
    wb(6'h3C, 1'b0, 8'h00, rd);
    `CHK("unmapped", 8'h00, rd)
    wb(ADR_WIDE_CTRL, 1'b0, 8'h00, rd);
    `CHK("wide ctrl reset", 8'h00, rd)
    wr(ADR_WIDE_CTRL, 8'h01);
    for (int i = 0; i < 4; i++) begin
      wr(ADR_SHARED_CTRL, sh_v[i]);
      settle();
      `CHK("idle or forced wide pin", sh_e[i], w_pin)
    end
    wr(ADR_NARROW_CTRL, 8'h01);
    for (int c = 0; c < 4; c++) begin
      wr(ADR_SHARED_CTRL, 8'h41 | 8'(c << 4));
      settle();
      `CHK("combined pin", comb_e[c], c_pin)
    end
    `CHK("narrow idle pin", 1'b1, n_pin)
    wr(ADR_SHARED_CTRL, 8'h00);
    wr(ADR_WIDE_RLD_HI, 8'h00);
    wr(ADR_WIDE_RLD_LO, 8'h10);
    wr(ADR_WIDE_CTRL, 8'hC3);
    settle();
    `CHK("initial level", 1'b0, w_pin)
    wait_to(t1);
    settle();
    `CHK("toggled pin", 1'b1, w_pin)
    wb(ADR_WIDE_CTRL, 1'b0, 8'h00, rd);
    `CHK("stopped with timeout", 8'h63, rd)
    wr(ADR_WIDE_CTRL, 8'h43);
    wb(ADR_WIDE_CTRL, 1'b0, 8'h00, rd);
    `CHK("write 0 keeps timeout", 8'h63, rd)
    wr(ADR_WIDE_CTRL, 8'h63);
    wb(ADR_WIDE_CTRL, 1'b0, 8'h00, rd);
    `CHK("write 1 clears timeout", 8'h43, rd)
    // modulo-n at divide by 8: period far longer than the divide-by-1 run
    wr(ADR_WIDE_CTRL, 8'h9B);
    wait_to(t8);
    `CHK("divide by 8 slower", 1'b1, t8 > 4 * t1)
    wait_to(t8);
    `CHK("modulo-n reloads", 1'b1, t8 < 3000)
    wr(ADR_WIDE_CTRL, 8'h20);
    wr(ADR_WIDE_RLD_HI, 8'hFF);
    wr(ADR_WIDE_RLD_LO, 8'hFF);
    wr(ADR_SHARED_CTRL, 8'hB0);
    wr(ADR_WIDE_CTRL, 8'h84);
    ir.mark(20);
    settle();
    `CHK("capture irq", 1'b1, cap_seen)
    wb(ADR_EDGE_STAT, 1'b0, 8'h00, rd);
    `CHK("falling edge status", 8'h01, rd)
    wb(ADR_WIDE_CAP_HI, 1'b0, 8'h00, rd);
    `CHK("capture high", 8'h00, rd)
    wb(ADR_WIDE_CAP_LO, 1'b0, 8'h00, rd);
    `CHK("capture low near 20", 1'b1, rd >= 8'd16 && rd <= 8'd24)
    wr(ADR_EDGE_STAT, 8'h03);
    wb(ADR_EDGE_STAT, 1'b0, 8'h00, rd);
    `CHK("edge status cleared", 8'h00, rd)
    // mark time: re-armed edge captures once, narrow timeouts capture after it
    wr(ADR_NARROW_CTRL, 8'h80);
    wr(ADR_WIDE_CTRL, 8'hC4);
    ir.mark(20);
    settle();
    wb(ADR_EDGE_STAT, 1'b0, 8'h00, rd);
    `CHK("re-armed rising edge only", 8'h02, rd)
    cap_seen <= 1'b0;
    repeat (300) @(posedge clk);
    `CHK("narrow timeout capture", 1'b1, cap_seen)
    // ping-pong from stopped counters with clean flags
    wr(ADR_WIDE_CTRL, 8'h20);
    wr(ADR_NARROW_CTRL, 8'h63);
    wr(ADR_NARROW_RLD_LO, 8'h20);
    wr(ADR_WIDE_RLD_HI, 8'h00);
    wr(ADR_WIDE_RLD_LO, 8'h0C);
    wr(ADR_WIDE_CTRL, 8'h43);
    wr(ADR_SHARED_CTRL, 8'h05);
    wr(ADR_NARROW_CTRL, 8'hC3);
    wait_to(t1);
    wb(ADR_NARROW_CTRL, 1'b0, 8'h00, rd);
    `CHK("narrow re-enabled", 8'hE3, rd)
    `CHK("narrow timeout irq", 1'b1, nto_seen)
    wr(ADR_SHARED_CTRL, 8'h01);
    wr(ADR_WIDE_CTRL, 8'h63);
    repeat (80) @(posedge clk);
    wb(ADR_WIDE_CTRL, 1'b0, 8'h00, rd);
    `CHK("ping-pong ended", 8'h43, rd)
    end_of_test();
  end
endmodule
`default_nettype wire
